// ---- shared/pmc_consts.svh ----
// Functional notes
// - Select high: interface standby, all pins but select and reset ignored.
// - Data phase with clock stable access_time plus 30 ns enters clock stop.
// - In clock stop during read, latched read data stays driven.
// - Clock toggling again leaves clock stop and resumes transfer.
// - Upper data lanes ignored in cmd_addr_phase; host still drives them.
// - Strobe driven low in cmd_addr_phase when no extra latency needed.
// - Sleep bit write enters hybrid_sleep within sleep_entry_time, 3 us.
// - Refresh continues in hybrid_sleep; array and registers retained.
// - Select low in hybrid_sleep exits it and clears the sleep bit.
// - Back to standby within sleep_wake_time, 100 us, after wake pulse.
// - Reset also ends hybrid_sleep but stops refresh; contents may be lost.
// - After sleep exit the configuration equals that at sleep entry.
// - Power-down bit cleared enters deep_power_down; refresh halts.
// - Contents invalid after deep_power_down ends.
// - Select low then high, or reset, exits deep_power_down.
// - After deep_power_down exit configuration returns to defaults.
// - Reset exit needs poweron_settle_time before standby.
// - Standby within powerdown_wake_time, 150 us, after wake pulse.
// - Power-down level reached within powerdown_entry_time, 3 us.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_CLK_PS 25000
`define PMC_ACS_EXTRA_NS 30
`define PMC_SLEEP_ENTRY_NS 3000
`define PMC_SLEEP_WAKE_NS 100000
`define PMC_PD_ENTRY_NS 3000
`define PMC_PD_WAKE_NS 150000
`define PMC_SETTLE_NS 150000
`define PMC_ACCESS_NS 40
`define PMC_SYNC_STAGES 3
`define PMC_CNT_W 16
`define PMC_PD_BIT_RESET 1'b1
`define PMC_SLEEP_BIT_RESET 1'b0
`endif

// ---- shared/pmc_pkg.sv ----
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_STANDBY     = 3'h0,
        PMC_SLEEP_ENTRY = 3'h1,
        PMC_SLEEP       = 3'h3,
        PMC_SLEEP_WAKE  = 3'h2,
        PMC_PD_ENTRY    = 3'h6,
        PMC_PD          = 3'h7,
        PMC_PD_WAKE     = 3'h5,
        PMC_SETTLE      = 3'h4
    } pmc_state_type;
endpackage : pmc_pkg

// ---- core/pmc_power_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_power_mode_control #(
    parameter int ACCESS_NS = `PMC_ACCESS_NS,
    parameter int DQ_W = 16,
    parameter int PD_WAKE_CYC =
        (`PMC_PD_WAKE_NS * 1000) / `PMC_CLK_PS,
    parameter int SETTLE_CYC =
        (`PMC_SETTLE_NS * 1000) / `PMC_CLK_PS
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // link side, bus clock domain
    input wire logic link_clk_in,
    input wire logic select_n_in,
    input wire logic cmd_addr_phase_in,
    input wire logic data_phase_in,
    input wire logic read_phase_in,
    input wire logic extra_latency_in,
    input wire logic [DQ_W-1:0] dq_in,
    input wire logic [DQ_W-1:0] read_data_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic read_write_strobe_out,
    output logic read_write_strobe_oe_out,
    output logic [7:0] cmd_addr_byte_out,
    output logic cmd_addr_valid_out,
    // core side, mclk domain
    input wire logic sleep_bit_write_in,
    input wire logic pd_bit_clear_in,
    input wire logic mem_write_in,
    output logic sleep_bit_out,
    output logic pd_bit_out,
    output logic config_defaults_out,
    output logic refresh_en_out,
    output logic contents_invalid_out,
    output logic clock_stop_out,
    output logic standby_out,
    output logic interface_standby_out,
    output logic [2:0] power_state_out
);

    // ****************************************************
    // timing counts
    // ****************************************************
    localparam int ACS_CYC =
        ((ACCESS_NS + `PMC_ACS_EXTRA_NS) * 1000 + `PMC_CLK_PS - 1)
        / `PMC_CLK_PS;
    localparam int SLEEP_ENTRY_CYC =
        (`PMC_SLEEP_ENTRY_NS * 1000) / `PMC_CLK_PS;
    localparam int SLEEP_WAKE_CYC =
        (`PMC_SLEEP_WAKE_NS * 1000) / `PMC_CLK_PS;
    localparam int PD_ENTRY_CYC =
        (`PMC_PD_ENTRY_NS * 1000) / `PMC_CLK_PS;
    localparam int NS = `PMC_SYNC_STAGES;
    localparam int CW = `PMC_CNT_W;
    localparam int SW = 3;

    // ****************************************************
    // link domain
    // ****************************************************
    logic [DQ_W-1:0] read_hold;
    logic reading;

    // read data latched on each rising edge of a read data phase; a stopped clock keeps it
    always_ff @(posedge link_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            read_hold <= '0;
            reading <= 1'b0;
        end else if (select_n_in) begin
            reading <= 1'b0;
        end else begin
            reading <= data_phase_in & read_phase_in;
            if (data_phase_in && read_phase_in) begin
                read_hold <= read_data_in;
            end
        end
    end

    always_comb begin
        dq_out = read_hold;
        dq_oe_out = reading & ~select_n_in;
    end

    // only the low lanes carry command and address
    always_ff @(posedge link_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd_addr_byte_out <= 8'h00;
            cmd_addr_valid_out <= 1'b0;
        end else begin
            cmd_addr_valid_out <= ~select_n_in & cmd_addr_phase_in;
            if (!select_n_in && cmd_addr_phase_in) begin
                cmd_addr_byte_out <= dq_in[7:0];
            end
        end
    end

    // strobe low means single latency count
    always_comb begin
        read_write_strobe_out = extra_latency_in;
        read_write_strobe_oe_out = ~select_n_in & cmd_addr_phase_in;
    end

    // ****************************************************
    // crossings into mclk
    // ****************************************************
    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync_q [NS];
    logic [SW-1:0] filt;

    // bus clock level crosses itself, so both of its edges count
    assign raw_in = {select_n_in, link_clk_in, data_phase_in};

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NS; i++) begin
                sync_q[i] <= {1'b1, 2'b00};
            end
        end else begin
            sync_q[0] <= raw_in;
            for (int i = 1; i < NS; i++) begin
                sync_q[i] <= sync_q[i-1];
            end
        end
    end

    // a change counts once the last two stages agree
    genvar g;
    generate
        for (g = 0; g < SW; g++) begin : g_filt
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    filt[g] <= (g == SW - 1);
                end else if (sync_q[NS-2][g] == sync_q[NS-1][g]) begin
                    filt[g] <= sync_q[NS-1][g];
                end
            end
        end
    endgenerate

    logic sel_n;
    logic tog;
    logic in_data;
    logic tog_prev;
    logic sel_n_prev;

    assign sel_n = filt[2];
    assign tog = filt[1];
    assign in_data = filt[0];

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tog_prev <= 1'b0;
            sel_n_prev <= 1'b1;
        end else begin
            tog_prev <= tog;
            sel_n_prev <= sel_n;
        end
    end

    // ****************************************************
    // active clock stop
    // ****************************************************
    logic [CW-1:0] idle_cnt;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idle_cnt <= '0;
            clock_stop_out <= 1'b0;
        end else if (sel_n || !in_data || tog != tog_prev) begin
            idle_cnt <= '0;
            clock_stop_out <= 1'b0;
        end else if (idle_cnt < CW'(ACS_CYC)) begin
            idle_cnt <= idle_cnt + 1'b1;
        end else begin
            clock_stop_out <= 1'b1;
        end
    end

    // ****************************************************
    // power mode machine
    // ****************************************************
    pmc_pkg::pmc_state_type state;
    pmc_pkg::pmc_state_type next_state;
    logic [CW-1:0] cnt;
    logic cnt_done;
    logic sel_rise;
    logic sel_fall;

    assign sel_rise = sel_n & ~sel_n_prev;
    assign sel_fall = ~sel_n & sel_n_prev;

    always_comb begin
        cnt_done = 1'b0;
        case (state)
            pmc_pkg::PMC_SLEEP_ENTRY:
                cnt_done = cnt >= CW'(SLEEP_ENTRY_CYC - 1);
            pmc_pkg::PMC_SLEEP_WAKE:
                cnt_done = cnt >= CW'(SLEEP_WAKE_CYC - 1);
            pmc_pkg::PMC_PD_ENTRY:
                cnt_done = cnt >= CW'(PD_ENTRY_CYC - 1);
            pmc_pkg::PMC_PD_WAKE:
                cnt_done = cnt >= CW'(PD_WAKE_CYC - 1);
            pmc_pkg::PMC_SETTLE:
                cnt_done = cnt >= CW'(SETTLE_CYC - 1);
            default:
                cnt_done = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            pmc_pkg::PMC_STANDBY: begin
                if (sleep_bit_write_in) begin
                    next_state = pmc_pkg::PMC_SLEEP_ENTRY;
                end else if (pd_bit_clear_in) begin
                    next_state = pmc_pkg::PMC_PD_ENTRY;
                end
            end
            pmc_pkg::PMC_SLEEP_ENTRY: begin
                if (cnt_done) begin
                    next_state = pmc_pkg::PMC_SLEEP;
                end
            end
            pmc_pkg::PMC_SLEEP: begin
                if (sel_fall) begin
                    next_state = pmc_pkg::PMC_SLEEP_WAKE;
                end
            end
            pmc_pkg::PMC_SLEEP_WAKE: begin
                if (cnt_done) begin
                    next_state = pmc_pkg::PMC_STANDBY;
                end
            end
            pmc_pkg::PMC_PD_ENTRY: begin
                if (cnt_done) begin
                    next_state = pmc_pkg::PMC_PD;
                end
            end
            pmc_pkg::PMC_PD: begin
                if (sel_rise) begin
                    next_state = pmc_pkg::PMC_PD_WAKE;
                end
            end
            pmc_pkg::PMC_PD_WAKE: begin
                if (cnt_done) begin
                    next_state = pmc_pkg::PMC_STANDBY;
                end
            end
            pmc_pkg::PMC_SETTLE: begin
                if (cnt_done) begin
                    next_state = pmc_pkg::PMC_STANDBY;
                end
            end
            default: begin
                next_state = pmc_pkg::PMC_SETTLE;
            end
        endcase
    end

    // reset ends any mode through the settle wait
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= pmc_pkg::PMC_SETTLE;
        end else begin
            state <= next_state;
        end
    end

    // wake counts start once the wake pulse has ended
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else if (state == pmc_pkg::PMC_SLEEP_WAKE && !sel_n) begin
            cnt <= '0;
        end else if (!cnt_done) begin
            cnt <= cnt + 1'b1;
        end
    end

    // ****************************************************
    // configuration bits
    // ****************************************************
    // sleep bit: set by write, cleared by select low in sleep
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sleep_bit_out <= `PMC_SLEEP_BIT_RESET;
        end else if (sleep_bit_write_in) begin
            sleep_bit_out <= 1'b1;
        end else if (state == pmc_pkg::PMC_SLEEP && sel_fall) begin
            sleep_bit_out <= 1'b0;
        end else if (state == pmc_pkg::PMC_PD_WAKE && cnt_done) begin
            sleep_bit_out <= `PMC_SLEEP_BIT_RESET;
        end
    end

    // other settings untouched across sleep
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pd_bit_out <= `PMC_PD_BIT_RESET;
            config_defaults_out <= 1'b0;
        end else begin
            config_defaults_out <= 1'b0;
            if (state == pmc_pkg::PMC_PD_WAKE && cnt_done) begin
                pd_bit_out <= `PMC_PD_BIT_RESET;
                config_defaults_out <= 1'b1;
            end else if (pd_bit_clear_in &&
                         state == pmc_pkg::PMC_STANDBY) begin
                pd_bit_out <= 1'b0;
            end
        end
    end

    // ****************************************************
    // refresh and array validity
    // ****************************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            contents_invalid_out <= 1'b1;
        end else if (next_state == pmc_pkg::PMC_PD) begin
            contents_invalid_out <= 1'b1;
        end else if (mem_write_in) begin
            contents_invalid_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            refresh_en_out <= 1'b0;
        end else begin
            case (next_state)
                pmc_pkg::PMC_PD,
                pmc_pkg::PMC_PD_WAKE,
                pmc_pkg::PMC_SETTLE: refresh_en_out <= 1'b0;
                default: refresh_en_out <= 1'b1;
            endcase
        end
    end

    // ****************************************************
    // status
    // ****************************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            standby_out <= 1'b0;
            interface_standby_out <= 1'b0;
            power_state_out <= pmc_pkg::PMC_SETTLE;
        end else begin
            standby_out <= next_state == pmc_pkg::PMC_STANDBY;
            interface_standby_out <=
                (next_state == pmc_pkg::PMC_STANDBY) & sel_n;
            power_state_out <= next_state;
        end
    end

endmodule : pmc_power_mode_control

`default_nettype wire

// ---- tb/pmc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_chk #(
    parameter int PD_WAKE_CYC = 50
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic link_clk_in,
    input wire logic select_n_in,
    input wire logic cmd_addr_phase_in,
    input wire logic data_phase_in,
    input wire logic extra_latency_in,
    input wire logic sleep_bit_write_in,
    input wire logic pd_bit_clear_in,
    input wire logic [15:0] dq_out,
    input wire logic read_write_strobe_out,
    input wire logic read_write_strobe_oe_out,
    input wire logic sleep_bit_out,
    input wire logic pd_bit_out,
    input wire logic refresh_en_out,
    input wire logic contents_invalid_out,
    input wire logic clock_stop_out,
    input wire logic [2:0] power_state_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    int wake_cnt;
    // ****************************************
    // cycles spent in the power-down wake state
    // ****************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_cnt <= 0;
        end else if (power_state_out == 3'h5) begin
            wake_cnt <= wake_cnt + 1;
        end else begin
            wake_cnt <= 0;
        end
    end
    chk_sleep_entry: assert property (sleep_bit_write_in &&
        power_state_out == 3'h0 |=> power_state_out == 3'h1 && sleep_bit_out)
        else $error("sleep request not taken");
    chk_sleep_reach: assert property (power_state_out == 3'h1
        |-> ##[0:121] power_state_out == 3'h3)
        else $error("sleep level late");
    chk_sleep_refresh: assert property (power_state_out == 3'h3
        |-> refresh_en_out) else $error("refresh off in sleep");
    chk_sleep_exit_clr: assert property (power_state_out == 3'h2
        |-> !sleep_bit_out) else $error("sleep bit kept on exit");
    chk_pd_entry: assert property (pd_bit_clear_in &&
        !sleep_bit_write_in && power_state_out == 3'h0
        |=> power_state_out == 3'h6 && !pd_bit_out)
        else $error("power down request not taken");
    chk_pd_reach: assert property (power_state_out == 3'h6
        |-> ##[0:121] power_state_out == 3'h7) else $error("pd level late");
    chk_pd_halt: assert property (power_state_out == 3'h7
        |-> !refresh_en_out && contents_invalid_out)
        else $error("refresh or contents wrong in power down");
    chk_pd_wake_bound: assert property (wake_cnt <= PD_WAKE_CYC + 2)
        else $error("power down wake too long");
    chk_exit_defaults: assert property (power_state_out == 3'h5 ##1
        power_state_out == 3'h0 |-> pd_bit_out && !sleep_bit_out)
        else $error("config not default after power down");
    chk_stop_hold: assert property ($rose(clock_stop_out)
        |-> !link_clk_in && data_phase_in && $stable(dq_out))
        else $error("clock stop entered wrongly");
    chk_stop_leave: assert property ($rose(link_clk_in)
        |-> ##[1:6] !clock_stop_out) else $error("clock stop not left");
    chk_strobe_ca: assert property (@(posedge link_clk_in)
        disable iff (!reset_n_in) !select_n_in && cmd_addr_phase_in
        |-> read_write_strobe_oe_out &&
        read_write_strobe_out == extra_latency_in)
        else $error("strobe wrong in command phase");
endmodule : pmc_chk
bind pmc_power_mode_control pmc_chk #(.PD_WAKE_CYC(PD_WAKE_CYC)) chk_u (.*);
`default_nettype wire

// ---- tb/pmc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
    output logic link_clk_out,
    output logic select_n_out,
    output logic cmd_addr_phase_out,
    output logic data_phase_out,
    output logic read_phase_out,
    output logic [15:0] dq_out,
    output logic [15:0] read_data_out
);
    initial begin
        link_clk_out = 1'b0;
        select_n_out = 1'b1;
        cmd_addr_phase_out = 1'b0;
        data_phase_out = 1'b0;
        read_phase_out = 1'b0;
        dq_out = 16'h0000;
        read_data_out = 16'h0000;
    end
    // ****************************************
    // one clock; it rests low after
    // ****************************************
    task automatic ca_cycle(input logic [15:0] d);
        select_n_out = 1'b0;
        cmd_addr_phase_out = 1'b1;
        dq_out = d; // upper lanes still driven
        #62.5 link_clk_out = 1'b1;
        #1 cmd_addr_phase_out = 1'b0;
        dq_out = ~d;
        #61.5 link_clk_out = 1'b0;
    endtask : ca_cycle
    task automatic rd_cycle(input logic [15:0] d);
        data_phase_out = 1'b1;
        read_phase_out = 1'b1;
        read_data_out = d;
        #62.5 link_clk_out = 1'b1;
        #1 read_data_out = ~d;
        #61.5 link_clk_out = 1'b0;
    endtask : rd_cycle
    task automatic end_frame; // select raised in time
        data_phase_out = 1'b0;
        read_phase_out = 1'b0;
        select_n_out = 1'b1;
    endtask : end_frame
    task automatic wake(input int ns);
        select_n_out = 1'b0;
        #(ns) select_n_out = 1'b1;
    endtask : wake
endmodule : pmc_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk_in, reset_n_in, sleep_bit_write_in, pd_bit_clear_in;
    logic mem_write_in, link_clk_in, select_n_in, cmd_addr_phase_in;
    logic data_phase_in, read_phase_in, extra_latency_in;
    logic [15:0] dq_in, read_data_in, dq_out;
    logic dq_oe_out, read_write_strobe_out, read_write_strobe_oe_out;
    logic cmd_addr_valid_out, sleep_bit_out, pd_bit_out;
    logic config_defaults_out, refresh_en_out, contents_invalid_out;
    logic clock_stop_out, standby_out, interface_standby_out;
    logic [7:0] cmd_addr_byte_out;
    logic [2:0] power_state_out;
    int err_total = 0;
    int comparisons = 0;
    pmc_power_mode_control #(.PD_WAKE_CYC(50), .SETTLE_CYC(20)) dut_u (.*);
    pmc_host_model host_u (
        .link_clk_out(link_clk_in),
        .select_n_out(select_n_in),
        .cmd_addr_phase_out(cmd_addr_phase_in),
        .data_phase_out(data_phase_in),
        .read_phase_out(read_phase_in),
        .dq_out(dq_in),
        .read_data_out(read_data_in)
    );
    // ****************************************
    // clock, checking and closing
    // ****************************************
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic wait_st(input logic [2:0] code, input int lim);
        int n;
        n = 0;
        while (power_state_out !== code && n < lim) begin
            @(negedge mclk_in);
            n++;
        end
        check(power_state_out, code);
    endtask : wait_st
    task automatic t_sleep;
        @(negedge mclk_in) mem_write_in = 1'b1;
        @(negedge mclk_in) mem_write_in = 1'b0;
        sleep_bit_write_in = 1'b1;
        @(negedge mclk_in) sleep_bit_write_in = 1'b0;
        check(sleep_bit_out, 1'b1);
        wait_st(3'h3, 125);
        check(refresh_en_out, 1'b1);
        host_u.wake(200);
        wait_st(3'h2, 10);
        check(sleep_bit_out, 1'b0);
        wait_st(3'h0, 4010);
        check(pd_bit_out, 1'b1);
        check(contents_invalid_out, 1'b0);
        check(config_defaults_out, 1'b0);
    endtask : t_sleep
    task automatic t_pd;
        @(negedge mclk_in) pd_bit_clear_in = 1'b1;
        @(negedge mclk_in) pd_bit_clear_in = 1'b0;
        check(pd_bit_out, 1'b0);
        wait_st(3'h7, 125);
        check(refresh_en_out, 1'b0);
        host_u.wake(400);
        wait_st(3'h0, 60); // host waits for standby
        check(config_defaults_out, 1'b1);
        check(standby_out, 1'b1);
        check(pd_bit_out, 1'b1);
        check(contents_invalid_out, 1'b1);
    endtask : t_pd
    task automatic t_link;
        #7;
        fork
            host_u.ca_cycle(16'hA512);
            #30 check(read_write_strobe_oe_out, 1'b1);
        join
        check(read_write_strobe_out, 1'b0);
        check(cmd_addr_byte_out, 8'h12);
        check(cmd_addr_valid_out, 1'b1);
        extra_latency_in = 1'b1;
        fork
            host_u.ca_cycle(16'h3C56);
            #30 check(read_write_strobe_out, 1'b1);
        join
        extra_latency_in = 1'b0;
        check(cmd_addr_byte_out, 8'h56);
        host_u.rd_cycle(16'h1111);
        host_u.rd_cycle(16'h2222);
        repeat (20) @(negedge mclk_in);
        check(cmd_addr_valid_out, 1'b0);
        check(clock_stop_out, 1'b1);
        check(dq_out, 16'h2222);
        check(dq_oe_out, 1'b1);
        host_u.rd_cycle(16'h3333);
        host_u.rd_cycle(16'h4444);
        check(clock_stop_out, 1'b0);
        check(dq_out, 16'h4444);
        host_u.end_frame();
        repeat (6) @(negedge mclk_in);
        check(interface_standby_out, 1'b1);
    endtask : t_link
    task automatic t_reset_sleep;
        @(negedge mclk_in) sleep_bit_write_in = 1'b1;
        @(negedge mclk_in) sleep_bit_write_in = 1'b0;
        wait_st(3'h3, 125);
        reset_n_in = 1'b0;
        @(negedge mclk_in);
        check(refresh_en_out, 1'b0);
        check(sleep_bit_out, 1'b0);
        check(contents_invalid_out, 1'b1);
        reset_n_in = 1'b1;
        wait_st(3'h0, 30);
    endtask : t_reset_sleep
    initial begin
        reset_n_in = 1'b0;
        {sleep_bit_write_in, pd_bit_clear_in, mem_write_in} = 3'h0;
        extra_latency_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        check(power_state_out, 3'h4);
        check(pd_bit_out, 1'b1);
        reset_n_in = 1'b1;
        wait_st(3'h0, 30);
        check(standby_out, 1'b1);
        t_sleep();
        t_pd();
        t_link();
        t_reset_sleep();
        conclude();
    end
    initial begin
        #400us;
        err_total++;
        conclude();
    end
endmodule : tb
`default_nettype wire
